/* File: design/vfp_pkg.sv */
package vfp_pkg;
   // ------------------------------------------------------------
   // message header
   // ------------------------------------------------------------
   localparam int HDR_BYTES = 20;
   localparam logic [15:0] HDR_LEN = 16'(HDR_BYTES);
   localparam logic [31:0] CMD_REQ = 32'h3600_0000;
   localparam logic [31:0] CMD_ACC = 32'h0200_0000;
   localparam logic [23:0] FC_ADDR = 24'h0F_FFFD;
   localparam logic [7:0] VER_OWN = 8'h01;
   localparam logic [7:0] VER_NONE = 8'h00;
   localparam logic [7:0] MSG_SYNC = 8'h01;
   localparam logic [7:0] MSG_COMMIT = 8'h02;
   localparam logic [4:0] POS_VER = 5'h04;
   localparam logic [4:0] POS_CODE = 5'h05;
   localparam logic [4:0] POS_TXN = 5'h06;
   localparam logic [4:0] POS_LEN = 5'h12;
   // ------------------------------------------------------------
   // descriptors
   // ------------------------------------------------------------
   localparam logic [15:0] DESC_HDR_LAST = 16'h0003;
   localparam logic [7:0] DC_CRIT = 8'h01;
   localparam logic [7:0] DC_SKIP = 8'h02;
   localparam logic [7:0] DT_TAG = 8'h01;
   localparam logic [7:0] DT_LIST = 8'h03;
   localparam logic [7:0] DT_VEN_LO = 8'hF0;
   localparam logic [7:0] DT_VEN_HI = 8'hFE;
   localparam logic [15:0] LEN_TAG = 16'h0004;
   localparam logic [15:0] LEN_PVF = 16'h0004;
   localparam logic [15:0] LEN_LIST = 16'h0200;
   // ------------------------------------------------------------
   // reject reasons and explanations
   // ------------------------------------------------------------
   localparam logic [7:0] RC_NOT_SUPP = 8'h0B;
   localparam logic [7:0] RC_UNABLE = 8'h09;
   localparam logic [7:0] RC_INV_REV = 8'h02;
   localparam logic [7:0] RC_LOGICAL = 8'h03;
   localparam logic [7:0] RC_PROTO = 8'h07;
   localparam logic [7:0] EX_NONE = 8'h00;
   localparam logic [7:0] EX_IN_PROG = 8'h0A;
   localparam logic [7:0] EX_NO_RES = 8'h0B;
   // ------------------------------------------------------------
   // register map
   // ------------------------------------------------------------
   localparam logic [11:0] A_CTRL = 12'h000;
   localparam logic [11:0] A_VER = 12'h004;
   localparam logic [11:0] A_LOCLEN = 12'h008;
   localparam logic [11:0] A_STAT = 12'h00C;
   localparam int CB_SVC = 0;
   localparam int CB_RES = 1;
   localparam int CB_BUSY = 2;
   localparam logic [15:0] LOCLEN_RST = 16'h0214;
   typedef enum logic [1:0] {S_RX, S_EVAL, S_ACC, S_RJT} vfp_state_t;
   typedef enum logic [1:0] {DK_KNOWN, DK_VENDOR, DK_RESV} vfp_dkind_t;
endpackage

/* File: design/vfp_desc_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface vfp_desc_if;
   logic start;
   logic valid;
   logic last;
   logic [7:0] data;
   logic errPay;
   logic errCrit;
   modport src (output start, valid, last, data, input errPay, errCrit);
   modport chk (input start, valid, last, data, output errPay, errCrit);
endinterface
`default_nettype wire

/* File: design/vfp_desc_check.sv */
`timescale 1ns/1ps
`default_nettype none
module vfp_desc_check
   import vfp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   vfp_desc_if.chk d
);
   logic [15:0] pos_r;
   logic [15:0] len_r;
   logic [7:0] ctl_r;
   logic [7:0] typ_r;
   logic [1:0] cnt_r;
   logic errPay_r;
   logic errCrit_r;
   logic [15:0] effLen;
   logic [16:0] endPos;
   logic [15:0] expLen;
   logic descEnd;
   logic badDesc;
   logic critHit;
   vfp_dkind_t kind;

   always_comb begin
      // length field excludes the four control/type/length bytes
      effLen = (pos_r == DESC_HDR_LAST) ? {len_r[15:8], d.data} : len_r;
      endPos = {1'b0, effLen} + {1'b0, DESC_HDR_LAST};
      descEnd = d.valid && (pos_r >= DESC_HDR_LAST) && ({1'b0, pos_r} == endPos);
      if (typ_r >= DT_TAG && typ_r <= DT_LIST) begin
         kind = DK_KNOWN;
      end else if (typ_r >= DT_VEN_LO && typ_r <= DT_VEN_HI) begin
         kind = DK_VENDOR;
      end else begin
         kind = DK_RESV;
      end
      case (cnt_r)
         2'h0: expLen = LEN_TAG;
         2'h1: expLen = LEN_PVF;
         default: expLen = LEN_LIST;
      endcase
      badDesc = 1'b0;
      critHit = 1'b0;
      if (cnt_r != 2'h3) begin
         // first three slots are fixed in type and size
         badDesc = (typ_r != DT_TAG + {6'h00, cnt_r}) || (effLen != expLen);
      end else if (kind != DK_KNOWN) begin
         // vendor and reserved types are not understood here, so control decides
         critHit = (ctl_r == DC_CRIT);
         badDesc = (ctl_r != DC_CRIT) && (ctl_r != DC_SKIP);
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         pos_r <= 16'h0000;
         len_r <= 16'h0000;
         ctl_r <= 8'h00;
         typ_r <= 8'h00;
         cnt_r <= 2'h0;
      end else if (d.start) begin
         pos_r <= 16'h0000;
         len_r <= 16'h0000;
         ctl_r <= 8'h00;
         typ_r <= 8'h00;
         cnt_r <= 2'h0;
      end else if (d.valid) begin
         case (pos_r)
            16'h0000: ctl_r <= d.data;
            16'h0001: typ_r <= d.data;
            16'h0002: len_r <= {d.data, 8'h00};
            default: len_r <= effLen;
         endcase
         if (descEnd) begin
            pos_r <= 16'h0000;
            if (cnt_r != 2'h3) begin
               cnt_r <= cnt_r + 2'h1;
            end
         end else begin
            pos_r <= pos_r + 16'h0001;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         errPay_r <= 1'b0;
         errCrit_r <= 1'b0;
      end else if (d.start) begin
         errPay_r <= 1'b0;
         errCrit_r <= 1'b0;
      end else if (d.valid) begin
         if (descEnd && badDesc) begin
            errPay_r <= 1'b1;
         end
         // a descriptor running past the payload end is malformed
         if (d.last && (!descEnd || cnt_r < 2'h2)) begin
            errPay_r <= 1'b1;
         end
         if (descEnd && critHit) begin
            errCrit_r <= 1'b1;
         end
      end
   end

   assign d.errPay = errPay_r;
   assign d.errCrit = errCrit_r;
endmodule
`default_nettype wire

/* File: design/vfp_param_exchange.sv */
`timescale 1ns/1ps
`default_nettype none
module vfp_param_exchange
   import vfp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic [11:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic pready,
   output logic [31:0] prdata,
   output logic pslverr,
   input wire logic rxValid,
   input wire logic [7:0] rxData,
   input wire logic rxLast,
   input wire logic [23:0] rxSid,
   input wire logic [23:0] rxDid,
   output logic rxReady,
   output logic txValid,
   output logic [7:0] txData,
   output logic txLast,
   output logic [23:0] txSid,
   output logic [23:0] txDid,
   input wire logic txReady,
   input wire logic locValid,
   input wire logic [7:0] locData,
   output logic locReady,
   output logic rjtValid,
   output logic [7:0] rjtReason,
   output logic [7:0] rjtExpl,
   input wire logic rjtReady
);
   vfp_state_t state_r;
   logic [7:0] hdr_r [HDR_BYTES];
   logic [15:0] rxCnt_r;
   logic [15:0] frameLen_r;
   logic addrOk_r;
   logic synced_r;
   logic [15:0] txn_r;
   logic [7:0] verOut_r;
   logic [15:0] totLen_r;
   logic [15:0] txIdx_r;
   logic txValid_r;
   logic [7:0] txData_r;
   logic txLast_r;
   logic [7:0] rjtReason_r;
   logic [7:0] rjtExpl_r;
   logic [7:0] lastRc_r;
   logic serviceEn_r;
   logic resOk_r;
   logic ownBusy_r;
   logic [7:0] supVer_r;
   logic [15:0] locLen_r;
   logic [31:0] prdata_r;
   logic rxTake;
   logic load;
   logic [7:0] srcByte;
   logic [31:0] reqCmd;
   logic [7:0] rxVer;
   logic [7:0] rxCode;
   logic [15:0] rxTxn;
   logic [15:0] rxPlen;
   logic isSync;
   logic isCommit;
   logic frameBad;
   logic rejNxt;
   logic [7:0] rcNxt;
   logic [7:0] exNxt;
   logic apbWr;
   logic addrHit;
   vfp_desc_if dsc ();

   vfp_desc_check u_desc (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .d(dsc)
   );

   // ------------------------------------------------------------
   // receive and header capture
   // ------------------------------------------------------------
   assign rxReady = (state_r == S_RX);
   assign rxTake = rxValid && rxReady;
   assign reqCmd = {hdr_r[0], hdr_r[1], hdr_r[2], hdr_r[3]};
   assign rxVer = hdr_r[POS_VER];
   assign rxCode = hdr_r[POS_CODE];
   // the exchange id of the carrying frame is not seen here at all
   assign rxTxn = {hdr_r[POS_TXN], hdr_r[POS_TXN + 5'h01]};
   assign rxPlen = {hdr_r[POS_LEN], hdr_r[POS_LEN + 5'h01]};
   assign isSync = (rxCode == MSG_SYNC);
   assign isCommit = (rxCode == MSG_COMMIT);

   genvar gi;
   generate
      for (gi = 0; gi < HDR_BYTES; gi++) begin : g_hdr
         always_ff @(posedge sys_clk or negedge rst_n) begin
            if (!rst_n) begin
               hdr_r[gi] <= 8'h00;
            end else if (rxTake && rxCnt_r == 16'(gi)) begin
               hdr_r[gi] <= rxData;
            end
         end
      end
   endgenerate

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rxCnt_r <= 16'h0000;
         frameLen_r <= 16'h0000;
         addrOk_r <= 1'b0;
      end else if (rxTake) begin
         if (rxLast) begin
            rxCnt_r <= 16'h0000;
            frameLen_r <= rxCnt_r + 16'h0001;
            addrOk_r <= (rxSid == FC_ADDR) && (rxDid == FC_ADDR);
         end else if (rxCnt_r != 16'hFFFF) begin
            rxCnt_r <= rxCnt_r + 16'h0001;
         end
      end
   end

   assign dsc.start = rxTake && (rxCnt_r == 16'h0000);
   // only sync payloads carry a descriptor list
   assign dsc.valid = rxTake && isSync && (rxCnt_r >= HDR_LEN);
   assign dsc.last = rxLast;
   assign dsc.data = rxData;

   // ------------------------------------------------------------
   // request evaluation
   // ------------------------------------------------------------
   always_comb begin
      frameBad = (reqCmd != CMD_REQ) || !(isSync || isCommit);
      if (frameLen_r < HDR_LEN || rxPlen != frameLen_r) begin
         frameBad = 1'b1;
      end
      // commit has no payload, a sync without one is malformed
      if ((isCommit && frameLen_r != HDR_LEN) || (isSync && frameLen_r == HDR_LEN)) begin
         frameBad = 1'b1;
      end
   end

   always_comb begin
      rejNxt = 1'b1;
      rcNxt = RC_PROTO;
      exNxt = EX_NONE;
      if (!serviceEn_r) begin
         rcNxt = RC_NOT_SUPP;
      end else if (rxVer == VER_NONE) begin
         rcNxt = RC_INV_REV;
      end else if (frameBad) begin
         rcNxt = RC_PROTO;
      end else if (ownBusy_r) begin
         rcNxt = RC_UNABLE;
         exNxt = EX_IN_PROG;
      end else if (isCommit && (!synced_r || rxTxn != txn_r)) begin
         rcNxt = RC_LOGICAL;
      end else if (!resOk_r) begin
         rcNxt = RC_UNABLE;
         exNxt = EX_NO_RES;
      end else if (dsc.errPay || dsc.errCrit) begin
         rcNxt = RC_PROTO;
      end else begin
         rejNxt = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= S_RX;
      end else begin
         case (state_r)
            S_RX: begin
               if (rxTake && rxLast) begin
                  state_r <= S_EVAL;
               end
            end
            S_EVAL: begin
               // misaddressed frames are dropped without any reply
               if (!addrOk_r) begin
                  state_r <= S_RX;
               end else if (rejNxt) begin
                  state_r <= S_RJT;
               end else begin
                  state_r <= S_ACC;
               end
            end
            S_ACC: begin
               if (load && txIdx_r == totLen_r - 16'h0001) begin
                  state_r <= S_RX;
               end
            end
            S_RJT: begin
               if (rjtReady) begin
                  state_r <= S_RX;
               end
            end
            default: state_r <= S_RX;
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         synced_r <= 1'b0;
         txn_r <= 16'h0000;
      end else if (state_r == S_EVAL && addrOk_r) begin
         if (dsc.errCrit) begin
            synced_r <= 1'b0;
         end else if (!rejNxt && isSync) begin
            synced_r <= 1'b1;
            txn_r <= rxTxn;
         end else if (!rejNxt) begin
            synced_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         verOut_r <= VER_OWN;
         totLen_r <= HDR_LEN;
         rjtReason_r <= 8'h00;
         rjtExpl_r <= 8'h00;
         lastRc_r <= 8'h00;
      end else if (state_r == S_EVAL && addrOk_r) begin
         // any incompatibility is ours to handle, so cap at our version
         verOut_r <= (rxVer > supVer_r) ? supVer_r : rxVer;
         totLen_r <= isSync ? HDR_LEN + locLen_r : HDR_LEN;
         rjtReason_r <= rcNxt;
         rjtExpl_r <= exNxt;
         lastRc_r <= rejNxt ? rcNxt : 8'h00;
      end
   end

   // ------------------------------------------------------------
   // accept transmit
   // ------------------------------------------------------------
   assign load = (state_r == S_ACC) && (!txValid_r || txReady) && (txIdx_r < HDR_LEN || locValid);
   assign locReady = load && (txIdx_r >= HDR_LEN);

   always_comb begin
      if (txIdx_r >= HDR_LEN) begin
         srcByte = locData;
      end else begin
         case (txIdx_r[4:0])
            5'h00: srcByte = CMD_ACC[31:24];
            5'h01: srcByte = CMD_ACC[23:16];
            5'h02: srcByte = CMD_ACC[15:8];
            5'h03: srcByte = CMD_ACC[7:0];
            POS_VER: srcByte = verOut_r;
            POS_LEN: srcByte = totLen_r[15:8];
            POS_LEN + 5'h01: srcByte = totLen_r[7:0];
            default: srcByte = hdr_r[txIdx_r[4:0]];
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         txIdx_r <= 16'h0000;
         txValid_r <= 1'b0;
         txData_r <= 8'h00;
         txLast_r <= 1'b0;
      end else begin
         if (state_r == S_EVAL) begin
            txIdx_r <= 16'h0000;
         end else if (load) begin
            txIdx_r <= txIdx_r + 16'h0001;
         end
         if (load) begin
            txValid_r <= 1'b1;
            txData_r <= srcByte;
            txLast_r <= (txIdx_r == totLen_r - 16'h0001);
         end else if (txReady) begin
            txValid_r <= 1'b0;
         end
      end
   end

   assign txValid = txValid_r;
   assign txData = txData_r;
   assign txLast = txLast_r;
   assign txSid = FC_ADDR;
   assign txDid = FC_ADDR;
   assign rjtValid = (state_r == S_RJT);
   assign rjtReason = rjtReason_r;
   assign rjtExpl = rjtExpl_r;

   // ------------------------------------------------------------
   // register slave
   // ------------------------------------------------------------
   assign apbWr = psel && penable && pwrite;
   assign addrHit = (paddr == A_CTRL) || (paddr == A_VER) || (paddr == A_LOCLEN) || (paddr == A_STAT);
   assign pready = 1'b1;
   assign pslverr = psel && penable && !addrHit;
   assign prdata = prdata_r;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         serviceEn_r <= 1'b1;
         resOk_r <= 1'b1;
         ownBusy_r <= 1'b0;
         supVer_r <= VER_OWN;
         locLen_r <= LOCLEN_RST;
      end else if (apbWr) begin
         if (paddr == A_CTRL) begin
            serviceEn_r <= pwdata[CB_SVC];
            resOk_r <= pwdata[CB_RES];
            ownBusy_r <= pwdata[CB_BUSY];
         end
         if (paddr == A_VER) begin
            supVer_r <= pwdata[7:0];
         end
         if (paddr == A_LOCLEN) begin
            locLen_r <= pwdata[15:0];
         end
      end
   end

   // read data is latched in the setup phase so it is a flop output
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         prdata_r <= 32'h0000_0000;
      end else if (psel && !penable) begin
         case (paddr)
            A_CTRL: prdata_r <= {29'h0000_0000, ownBusy_r, resOk_r, serviceEn_r};
            A_VER: prdata_r <= {24'h00_0000, supVer_r};
            A_LOCLEN: prdata_r <= {16'h0000, locLen_r};
            A_STAT: prdata_r <= {txn_r, lastRc_r, 6'h00, (state_r != S_RX), synced_r};
            default: prdata_r <= 32'h0000_0000;
         endcase
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);

   a_accept_code: assert property (load && txIdx_r == 16'h0000 |=> txData_r == 8'h02 && txValid_r)
      else $error("accept reply does not open with accept code");
   a_ver_echo: assert property (state_r == S_EVAL && addrOk_r && rxVer <= supVer_r
      |=> verOut_r == $past(rxVer))
      else $error("reply version does not echo request version");
   a_ver_cap: assert property (state_r == S_EVAL && addrOk_r && rxVer > supVer_r
      |=> verOut_r == supVer_r)
      else $error("reply version not capped to supported version");
   a_no_service: assert property (state_r == S_EVAL && addrOk_r && !serviceEn_r
      |=> rjtValid && rjtReason == RC_NOT_SUPP && rjtExpl == EX_NONE)
      else $error("disabled service did not reject as not supported");
   a_logic_commit: assert property (rjtValid && rjtReason == RC_LOGICAL |-> isCommit)
      else $error("logical error raised for a non-commit request");
   a_collide_busy: assert property (rjtValid && rjtExpl == EX_IN_PROG |-> ownBusy_r || $past(ownBusy_r))
      else $error("collision reject without own transaction");
   a_len_field: assert property (load && txIdx_r == 16'(POS_LEN) + 16'h0001
      |=> txData_r == totLen_r[7:0])
      else $error("length field byte wrong in accept");
   a_rjt_hold: assert property (rjtValid && !rjtReady |=> rjtValid && $stable(rjtReason))
      else $error("reject dropped before taken");
   a_crit_abort: assert property (state_r == S_EVAL && addrOk_r && dsc.errCrit |=> !synced_r && rjtValid)
      else $error("critical descriptor did not abort transaction");
   a_reply_len: assert property (txValid && txLast && txReady && state_r == S_RX |-> totLen_r >= HDR_LEN)
      else $error("accept shorter than header");

   c_sync_acc: cover property (state_r == S_EVAL && addrOk_r && !rejNxt && isSync);
   c_commit_acc: cover property (state_r == S_EVAL && addrOk_r && !rejNxt && isCommit);
   c_reject: cover property (rjtValid && rjtReady);
   c_crit_abort: cover property (state_r == S_EVAL && addrOk_r && dsc.errCrit);
endmodule
`default_nettype wire

/* File: bench/vfp_peer_model.sv */
`timescale 1ns/1ps
`default_nettype none
module vfp_peer_model (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic stall,
   input wire logic txValid,
   input wire logic [7:0] txData,
   output logic txReady,
   input wire logic rjtValid,
   input wire logic [15:0] rjtCode,
   output logic rjtReady
);
   logic [7:0] got[$];
   logic [15:0] lastRjt;
   int rjtCnt = 0;
   // slow mode halves the sink rate so the block must hold each byte
   always @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         txReady <= 1'b0;
         rjtReady <= 1'b0;
      end else begin
         txReady <= stall ? ~txReady : 1'b1;
         rjtReady <= ~rjtReady;
         if (txValid && txReady) got.push_back(txData);
         if (rjtValid && rjtReady) begin
            lastRjt <= rjtCode;
            rjtCnt <= rjtCnt + 1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: bench/tb_vf_param_exchange_handler.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_vf_param_exchange_handler;
   import vfp_pkg::*;
   logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, er, stall = 0;
   logic rxValid = 0, rxLast = 0, rxReady, txValid, txLast, txReady, locValid = 1, locReady, rjtValid, rjtReady;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata, rd;
   logic [7:0] rxData = '0, txData, locData = 8'h40, rjtReason, rjtExpl;
   logic [23:0] rxSid = FC_ADDR, rxDid = FC_ADDR, txSid, txDid;
   int err_total = 0, samples_checked = 0, extra = 0;
   // trailing critical vendor descriptor with an empty value, appended when extra is 4
   localparam logic [7:0] VD[4] = '{8'h01, 8'hF0, 8'h00, 8'h00};
   localparam logic [7:0] PL[20] = '{8'h01, 8'h01, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h03, 8'h01, 8'h02,
      8'h00, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h03, 8'h02, 8'h00};
   vfp_param_exchange uut (.*);
   vfp_peer_model peer (.sys_clk(sys_clk), .rst_n(rst_n), .stall(stall), .txValid(txValid), .txData(txData),
      .txReady(txReady), .rjtValid(rjtValid), .rjtCode({rjtReason, rjtExpl}), .rjtReady(rjtReady));
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (locReady) locData <= locData + 8'h01;
   function automatic logic [7:0] fb(int i, logic [31:0] c4, logic [7:0] v, logic [7:0] c, logic [15:0] t,
      logic [15:0] l);
      case (i)
         0, 1, 2, 3: fb = c4[31-8*i -: 8];
         4: fb = v;
         5: fb = c;
         6: fb = t[15:8];
         7: fb = t[7:0];
         18: fb = l[15:8];
         19: fb = l[7:0];
         default: fb = (i < 16) ? 8'hA0 + 8'(i) : (i < 20) ? 8'h00 : (i < 40) ? PL[i-20] : 8'h5A;
      endcase
   endfunction
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      do @(posedge sys_clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic send(logic [7:0] v, logic [7:0] c, logic [15:0] t);
      int n;
      n = (c == MSG_SYNC) ? 552 + extra : 20;
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk);
         rxValid <= 1'b1;
         rxData <= (i >= 552) ? VD[i-552] : fb(i, CMD_REQ, v, c, t, 16'(n));
         rxLast <= (i == n - 1);
      end
      @(posedge sys_clk);
      rxValid <= 1'b0;
      rxLast <= 1'b0;
   endtask
   task automatic t_regs();
      apb(1'b0, A_VER, 32'h0000_0000);
      chk(rd, 32'h0000_0001);
      apb(1'b0, 12'h010, 32'h0000_0000);
      chk({31'h0, er}, 32'h0000_0001);
      apb(1'b1, A_LOCLEN, 32'h0000_0004);
      apb(1'b0, A_LOCLEN, 32'h0000_0000);
      chk(rd, 32'h0000_0004);
      $display("regs done");
   endtask
   task automatic rej(logic [31:0] ct, logic [7:0] v, logic [7:0] c, logic [15:0] t, logic [7:0] r, logic [7:0] x);
      int k;
      k = peer.rjtCnt;
      apb(1'b1, A_CTRL, ct);
      send(v, c, t);
      for (int j = 0; j < 300 && peer.rjtCnt == k; j++) @(posedge sys_clk);
      chk({16'h0, peer.lastRjt}, {16'h0, r, x});
      apb(1'b1, A_CTRL, 32'h0000_0003);
      $display("reject done");
   endtask
   task automatic acc(logic [7:0] v, logic [7:0] c, logic [15:0] t, logic [7:0] ev, int n);
      logic [7:0] lb;
      lb = locData;
      peer.got.delete();
      send(v, c, t);
      for (int j = 0; j < 2000 && peer.got.size() < 20 + n; j++) @(posedge sys_clk);
      chk(32'(peer.got.size()), 32'(20 + n));
      chk({8'h0, txSid}, {8'h0, FC_ADDR});
      for (int i = 0; i < 20; i++) chk({24'h0, peer.got[i]}, {24'h0, fb(i, CMD_ACC, ev, c, t, 16'(20 + n))});
      for (int i = 0; i < n; i++) chk({24'h0, peer.got[20+i]}, {24'h0, lb + 8'(i)});
      $display("accept done");
   endtask
   task automatic summarize();
      $display("checks=%0d mismatches=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_regs();
      rej(32'h3, VER_OWN, MSG_COMMIT, 16'h0005, RC_LOGICAL, EX_NONE);
      rej(32'h2, VER_OWN, MSG_COMMIT, 16'h0005, RC_NOT_SUPP, EX_NONE);
      rej(32'h3, VER_NONE, MSG_COMMIT, 16'h0005, RC_INV_REV, EX_NONE);
      rej(32'h7, VER_OWN, MSG_COMMIT, 16'h0005, RC_UNABLE, EX_IN_PROG);
      rej(32'h1, VER_OWN, MSG_SYNC, 16'h0005, RC_UNABLE, EX_NO_RES);
      rej(32'h3, VER_OWN, 8'h03, 16'h0005, RC_PROTO, EX_NONE);
      stall = 1'b1;
      acc(8'h02, MSG_SYNC, 16'h1234, VER_OWN, 4);
      stall = 1'b0;
      extra = 4;
      rej(32'h3, VER_OWN, MSG_SYNC, 16'h0077, RC_PROTO, EX_NONE);
      extra = 0;
      apb(1'b0, A_STAT, 32'h0000_0000);
      chk({31'h0, rd[0]}, 32'h0000_0000);
      acc(VER_OWN, MSG_SYNC, 16'h1234, VER_OWN, 4);
      acc(VER_OWN, MSG_COMMIT, 16'h1234, VER_OWN, 0);
      rej(32'h3, VER_OWN, MSG_COMMIT, 16'h1234, RC_LOGICAL, EX_NONE);
      summarize();
   end
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_total++;
      summarize();
   end
endmodule
`default_nettype wire
